// ---- dcrm_pkg.sv ----
// Package for the dual-core register map: address fields, module and
// register numbers, write masks of the implemented bits.
// Assumes an APB slave with 12 address bits, one 32-bit word per register.
package dcrm_pkg;

  // ==========================================================
  // Address fields (word index = {core, module, register})
  localparam int DCRM_ADDR_W = 12;      // APB address width
  localparam int REG_LSB     = 2;       // Register field low bit
  localparam int REG_MSB     = 6;       // Register field high bit
  localparam int MOD_LSB     = 7;       // Module field low bit
  localparam int MOD_MSB     = 10;      // Module field high bit
  localparam int CORE_BIT    = 11;      // 0 supervisory, 1 processing
  localparam int N_MODULES   = 16;      // Modules per core
  localparam int N_REGS      = 32;      // Registers per module
  localparam int N_PER_CORE  = N_MODULES * N_REGS;  // 512 registers

  // ==========================================================
  // Module numbers
  localparam logic [3:0] MOD_SYS_FIRST = 4'h7;  // System modules 7..15
  localparam logic [3:0] MOD_SYS       = 4'h8;  // Module holding our system regs
  localparam logic [3:0] MOD_PER_USR   = 4'h4;  // Supervisory peripherals 0..4
  localparam logic [3:0] MOD_PER_DSP   = 4'h0;  // Processing peripherals 0 only

  // ==========================================================
  // System register numbers inside MOD_SYS
  localparam logic [4:0] R_IMR  = 5'h00;  // interrupt_mask_register
  localparam logic [4:0] R_SC   = 5'h01;  // system_control_register
  localparam logic [4:0] R_IIR  = 5'h0B;  // interrupt_identification_register
  localparam logic [4:0] R_CLOCK_CONTROL_REGISTER = 5'h0E;  // clock_control_register
  localparam logic [4:0] R_WATCHDOG_CONTROL_REGISTER = 5'h0F;  // watchdog_control_register

  // Slots of the per-core system storage
  localparam int S_IMR  = 0;
  localparam int S_SC   = 1;
  localparam int S_CLOCK_CONTROL_REGISTER = 2;
  localparam int S_WATCHDOG_CONTROL_REGISTER = 3;
  localparam int N_SLOT = 4;

  // ==========================================================
  // Implemented-bit masks
  localparam logic [15:0] M_IMR_USR  = 16'h001F;  // No module_five_mask_bit
  localparam logic [15:0] M_IMR_DSP  = 16'h0001;  // module_zero_mask_bit only
  localparam logic [15:0] M_SC_USR   = 16'h00D7;  // No bits 3 and 5
  localparam logic [15:0] M_CLOCK_CONTROL_REGISTER_USR = 16'h006F;  // No stop bit 4 kept out
  localparam logic [15:0] M_CLOCK_CONTROL_REGISTER_DSP = 16'h0007;  // Divide and power bits only
  localparam logic [15:0] M_WATCHDOG_CONTROL_REGISTER_USR = 16'h00FF;  // Watchdog control
  localparam logic [15:0] M_CONVERTER_CONTROL     = 16'hFF7F;  // Bit 7 reads zero
  localparam logic [15:0] M_FULL     = 16'hFFFF;
  localparam logic [15:0] M_NONE     = 16'h0000;
  localparam int          CK_LOCKED_LOOP_MODE_BIT   = 5;         // locked_loop_mode_bit
  localparam int          CK_LOCKED_LOOP_SELECT_BIT   = 6;         // locked_loop_select_bit

  // ==========================================================
  // Supervisory peripheral register numbers
  localparam logic [4:0] R_ADC_HI_LAST = 5'h05;  // adc0..5_output
  localparam logic [4:0] R_ADC_LO_FST  = 5'h08;  // adc0..5_output_low
  localparam logic [4:0] R_ADC_LO_LAST = 5'h0D;
  localparam logic [4:0] R_SLAVE_RESPONSE_0 = 5'h06;
  localparam logic [4:0] R_SLAVE_RESPONSE_1 = 5'h07;
  localparam logic [4:0] R_MASTER_REQUEST_0 = 5'h0E;
  localparam logic [4:0] R_DECODER_SYNC_CONTROL  = 5'h13;  // Last writable reg of module 0
  localparam logic [4:0] R_CONVERTER_CONTROL  = 5'h11;
  localparam logic [4:0] R_PO0   = 5'h00;
  localparam logic [4:0] R_PO1   = 5'h01;
  localparam logic [4:0] R_PI0   = 5'h02;
  localparam logic [4:0] R_PI1   = 5'h03;
  localparam logic [4:0] R_PORT0_IRQ_FLAGS  = 5'h04;
  localparam logic [4:0] R_PORT0_IRQ_ENABLES  = 5'h05;
  localparam logic [5:0] PM_PO0  = 6'h20;  // Storage slot {mod[0], reg}
  localparam logic [5:0] PM_PO1  = 6'h21;
  localparam logic [5:0] PM_PORT0_IRQ_FLAGS = 6'h24;

endpackage : dcrm_pkg

// ---- dcrm_top.sv ----
// Dual-core register map: APB slave holding the system registers of a
// supervisory core and of a processing core, and the peripheral registers of the supervisory core.
// Assumes all inputs except the port pins come from logic on clk_in.
//
// Notes on behaviour
// - Sixteen modules of thirty-two registers per core.
// - System modules 7-15, peripheral modules 0-4 (processing core: 0 only).
// - Each core has separate register sets.
// - Supervisory mask and ident lack module five.
// - Supervisory control lacks segment and program bits.
// - Supervisory clock control: loop mode 5, select 6.
// - Processing mask and ident: module zero only.
// - Processing core has no system control register.
// - Processing core has no watchdog register.
// - Processing clock control lacks stop, switchback, loop bits.
// - Supervisory peripherals occupy modules zero to four.
//
// Design decisions made here: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module dcrm_top (
  // Clock and reset
  input  wire logic                  clk_in,
  input  wire logic                  srst_in,
  // APB slave
  input  wire logic                  psel_in,
  input  wire logic                  penable_in,
  input  wire logic                  pwrite_in,
  input  wire logic [11:0]           paddr_in,
  input  wire logic [31:0]           pwdata_in,
  output logic                       pready_out,
  output logic [31:0]                prdata_out,
  output logic                       pslverr_out,
  // Peripheral sources of the supervisory core, ident sources of both cores
  input  wire logic [15:0]           adc_high_in [6],
  input  wire logic [15:0]           adc_low_in  [6],
  input  wire logic [15:0]           port0_pins_in,
  input  wire logic [15:0]           port1_pins_in,
  input  wire logic [4:0]            usr_pending_in,
  input  wire logic                  dsp_pending_in,
  // Register-driven controls
  output logic [15:0]                port0_out,
  output logic [15:0]                port1_out,
  output logic [4:0]                 usr_irq_mask_out,
  output logic                       dsp_irq_mask_out,
  output logic                       fll_mode_out,
  output logic                       fll_select_out
);

  // ==========================================================
  // Address decode
  logic [3:0]  mod;                    // Module number
  logic [4:0]  rno;                    // Register number
  logic        core;                   // 1 selects processing core
  logic        setup;                  // APB setup cycle
  logic        wr_en;                  // Write takes effect this edge
  logic [15:0] wd;                     // Write data, low half

  assign mod   = paddr_in[dcrm_pkg::MOD_MSB:dcrm_pkg::MOD_LSB];
  assign rno   = paddr_in[dcrm_pkg::REG_MSB:dcrm_pkg::REG_LSB];
  assign core  = paddr_in[dcrm_pkg::CORE_BIT];
  assign setup = psel_in && !penable_in;
  assign wr_en = psel_in && penable_in && pwrite_in && !pslverr_out;
  assign wd    = pwdata_in[15:0];
  assign pready_out = 1'b1;            // Zero wait states

  // Module exists for this core
  function automatic logic mapped(input logic c, input logic [3:0] m);
    logic [3:0] top;
    top = c ? dcrm_pkg::MOD_PER_DSP : dcrm_pkg::MOD_PER_USR;
    mapped = (m >= dcrm_pkg::MOD_SYS_FIRST) || (m <= top);
  endfunction : mapped

  // Writable bits of a system register slot
  function automatic logic [15:0] sys_mask(input logic c, input logic [4:0] r);
    case (r)
      dcrm_pkg::R_IMR:  sys_mask = c ? dcrm_pkg::M_IMR_DSP  : dcrm_pkg::M_IMR_USR;
      dcrm_pkg::R_SC:   sys_mask = c ? dcrm_pkg::M_NONE     : dcrm_pkg::M_SC_USR;
      dcrm_pkg::R_CLOCK_CONTROL_REGISTER: sys_mask = c ? dcrm_pkg::M_CLOCK_CONTROL_REGISTER_DSP : dcrm_pkg::M_CLOCK_CONTROL_REGISTER_USR;
      dcrm_pkg::R_WATCHDOG_CONTROL_REGISTER: sys_mask = c ? dcrm_pkg::M_NONE     : dcrm_pkg::M_WATCHDOG_CONTROL_REGISTER_USR;
      default:          sys_mask = dcrm_pkg::M_NONE;
    endcase
  endfunction : sys_mask

  // Storage slot of a system register number
  function automatic int sys_slot(input logic [4:0] r);
    case (r)
      dcrm_pkg::R_IMR:  sys_slot = dcrm_pkg::S_IMR;
      dcrm_pkg::R_SC:   sys_slot = dcrm_pkg::S_SC;
      dcrm_pkg::R_CLOCK_CONTROL_REGISTER: sys_slot = dcrm_pkg::S_CLOCK_CONTROL_REGISTER;
      default:          sys_slot = dcrm_pkg::S_WATCHDOG_CONTROL_REGISTER;
    endcase
  endfunction : sys_slot

  // Writable bits of a supervisory peripheral register
  function automatic logic [15:0] per_mask(input logic [3:0] m, input logic [4:0] r);
    per_mask = dcrm_pkg::M_NONE;       // Read-only or absent
    if (m == 4'h0) begin
      if (r == dcrm_pkg::R_SLAVE_RESPONSE_0 || r == dcrm_pkg::R_SLAVE_RESPONSE_1) begin
        per_mask = dcrm_pkg::M_FULL;
      end else if (r == dcrm_pkg::R_CONVERTER_CONTROL) begin
        per_mask = dcrm_pkg::M_CONVERTER_CONTROL;
      end else if (r >= dcrm_pkg::R_MASTER_REQUEST_0 && r <= dcrm_pkg::R_DECODER_SYNC_CONTROL) begin
        per_mask = dcrm_pkg::M_FULL;
      end
    end else if (m == 4'h1) begin
      if (r == dcrm_pkg::R_PO0 || r == dcrm_pkg::R_PO1 ||
          r == dcrm_pkg::R_PORT0_IRQ_FLAGS || r == dcrm_pkg::R_PORT0_IRQ_ENABLES) begin
        per_mask = dcrm_pkg::M_FULL;
      end
    end
  endfunction : per_mask

  // ==========================================================
  // Port pin synchronisers and edge detect
  logic [15:0] pin_raw [2];            // Raw pins
  logic [15:0] pin_s1  [2];            // First stage
  logic [15:0] pin_s2  [2];            // Synchronised value
  logic [15:0] pin_d   [2];            // Previous synchronised value
  logic [15:0] port0_rise;             // Rising edges on port 0

  assign pin_raw[0] = port0_pins_in;
  assign pin_raw[1] = port1_pins_in;

  genvar gp;
  generate
    for (gp = 0; gp < 2; gp++) begin : g_sync
      // Two flops, then one for edge detection
      always_ff @(posedge clk_in) begin
        if (srst_in) begin
          pin_s1[gp] <= 16'h0000;
          pin_s2[gp] <= 16'h0000;
          pin_d[gp]  <= 16'h0000;
        end else begin
          pin_s1[gp] <= pin_raw[gp];
          pin_s2[gp] <= pin_s1[gp];
          pin_d[gp]  <= pin_s2[gp];
        end
      end
    end
  endgenerate

  assign port0_rise = pin_s2[0] & ~pin_d[0];

  // ==========================================================
  // System registers, one set per core
  logic [15:0] sysr [2][dcrm_pkg::N_SLOT];  // [core][slot]

  // Masked write; absent bits never load
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      for (int c = 0; c < 2; c++) begin
        for (int s = 0; s < dcrm_pkg::N_SLOT; s++) begin
          sysr[c][s] <= 16'h0000;
        end
      end
    end else if (wr_en && mod == dcrm_pkg::MOD_SYS && rno != dcrm_pkg::R_IIR) begin
      sysr[core][sys_slot(rno)] <= wd & sys_mask(core, rno);
    end
  end

  // ==========================================================
  // Supervisory peripheral storage, modules 0 and 1
  logic [15:0] pm [64];                // Indexed by {mod[0], reg}
  logic [5:0]  pm_idx;                 // Slot of current access
  logic        pm_hit;                 // Access targets stored peripheral

  assign pm_idx = {mod[0], rno};
  assign pm_hit = !core && (mod == 4'h0 || mod == 4'h1);

  // Writes, plus hardware-set port 0 flags
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      for (int i = 0; i < 64; i++) begin
        pm[i] <= 16'h0000;
      end
    end else begin
      if (wr_en && pm_hit) begin
        pm[pm_idx] <= wd & per_mask(mod, rno);
      end
      // Set wins over a clearing write in the same cycle
      if (|port0_rise) begin
        pm[dcrm_pkg::PM_PORT0_IRQ_FLAGS] <=
          ((wr_en && pm_hit && pm_idx == dcrm_pkg::PM_PORT0_IRQ_FLAGS) ? wd : pm[dcrm_pkg::PM_PORT0_IRQ_FLAGS])
          | port0_rise;
      end
    end
  end

  // ==========================================================
  // Read multiplexer
  logic [15:0] next_rd;                // Read value for this address
  logic        next_err;               // Unmapped module

  always_comb begin
    next_rd  = 16'h0000;
    next_err = !mapped(core, mod);
    if (mod == dcrm_pkg::MOD_SYS) begin
      if (rno == dcrm_pkg::R_IIR) begin
        // Only existing module bits report
        next_rd = core ? {15'h0000, dsp_pending_in}
                       : {11'h000, usr_pending_in};
      end else begin
        next_rd = sysr[core][sys_slot(rno)] & sys_mask(core, rno);
      end
    end else if (pm_hit) begin
      if (mod == 4'h0 && rno <= dcrm_pkg::R_ADC_HI_LAST) begin
        next_rd = adc_high_in[rno[2:0]];
      end else if (mod == 4'h0 && rno >= dcrm_pkg::R_ADC_LO_FST &&
                   rno <= dcrm_pkg::R_ADC_LO_LAST) begin
        next_rd = adc_low_in[3'(rno - dcrm_pkg::R_ADC_LO_FST)];
      end else if (mod == 4'h1 && rno == dcrm_pkg::R_PI0) begin
        next_rd = pin_s2[0];
      end else if (mod == 4'h1 && rno == dcrm_pkg::R_PI1) begin
        next_rd = pin_s2[1];
      end else begin
        next_rd = pm[pm_idx];          // Absent slots hold zero
      end
    end
  end

  // Answer captured in the setup cycle, held through access
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      prdata_out  <= 32'h0000_0000;
      pslverr_out <= 1'b0;
    end else if (setup) begin
      prdata_out  <= {16'h0000, next_rd};
      pslverr_out <= next_err;
    end
  end

  // ==========================================================
  // Control outputs
  assign port0_out        = pm[dcrm_pkg::PM_PO0];
  assign port1_out        = pm[dcrm_pkg::PM_PO1];
  assign usr_irq_mask_out = sysr[0][dcrm_pkg::S_IMR][4:0];
  assign dsp_irq_mask_out = sysr[1][dcrm_pkg::S_IMR][0];
  assign fll_mode_out     = sysr[0][dcrm_pkg::S_CLOCK_CONTROL_REGISTER][dcrm_pkg::CK_LOCKED_LOOP_MODE_BIT];
  assign fll_select_out   = sysr[0][dcrm_pkg::S_CLOCK_CONTROL_REGISTER][dcrm_pkg::CK_LOCKED_LOOP_SELECT_BIT];

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (srst_in);

  sequence s_setup;
    psel_in && !penable_in;
  endsequence

  sequence s_access;
    psel_in && penable_in;
  endsequence

  a_dsp_imr_zero: assert property (
    sysr[1][dcrm_pkg::S_IMR][15:1] == 15'h0000)
    else $error("processing mask holds bits above module zero");

  a_usr_imr_five: assert property (
    (wr_en && !core && mod == dcrm_pkg::MOD_SYS && rno == dcrm_pkg::R_IMR)
    |=> (usr_irq_mask_out == $past(wd[4:0])) && !sysr[0][dcrm_pkg::S_IMR][5])
    else $error("supervisory mask write wrong");

  a_sc_bits_zero: assert property (
    !sysr[0][dcrm_pkg::S_SC][3] && !sysr[0][dcrm_pkg::S_SC][5])
    else $error("absent control bits set");

  a_fll_write: assert property (
    (wr_en && !core && mod == dcrm_pkg::MOD_SYS && rno == dcrm_pkg::R_CLOCK_CONTROL_REGISTER)
    |=> fll_mode_out == $past(wd[5]) && fll_select_out == $past(wd[6]))
    else $error("loop control bits not loaded");

  a_dsp_sc_read: assert property (
    (s_setup ##0 (core && mod == dcrm_pkg::MOD_SYS && rno == dcrm_pkg::R_SC))
    |=> s_access |-> prdata_out == 32'h0000_0000)
    else $error("processing control register not empty");

  a_dsp_no_wdog: assert property (
    sysr[1][dcrm_pkg::S_WATCHDOG_CONTROL_REGISTER] == 16'h0000 && sysr[1][dcrm_pkg::S_SC] == 16'h0000)
    else $error("processing watchdog storage used");

  a_dsp_clock_control_register: assert property (
    sysr[1][dcrm_pkg::S_CLOCK_CONTROL_REGISTER][15:3] == 13'h0000)
    else $error("processing clock control holds absent bits");

  a_core_split: assert property (
    (wr_en && core) |=> $stable(sysr[0][dcrm_pkg::S_IMR]) && $stable(port0_out))
    else $error("processing write touched supervisory state");

  a_mod_error: assert property (
    (s_setup ##0 (mod > 4'h4 && mod < dcrm_pkg::MOD_SYS_FIRST)) |=> pslverr_out)
    else $error("module five or six answered");

  a_usr_modules: assert property (
    (s_setup ##0 (!core && mod <= dcrm_pkg::MOD_PER_USR)) |=> !pslverr_out)
    else $error("supervisory peripheral module refused");

  a_addr_fields: assert property (
    s_setup |-> (32'(mod) * 32'(dcrm_pkg::N_REGS) + 32'(rno)) < dcrm_pkg::N_PER_CORE)
    else $error("register index beyond per-core space");

  a_absent_zero: assert property (
    (s_setup ##0 (!core && mod == 4'h0 && rno == dcrm_pkg::R_CONVERTER_CONTROL)) |=> !prdata_out[7])
    else $error("absent converter bit reads one");

  // ==========================================================
  // Answer path and storage checks
  // Zero wait states: every access completes at once
  a_ready_high: assert property (
    pready_out)
    else $error("ready dropped");

  // Registers are one half word, upper read bits stay clear
  a_upper_zero: assert property (
    prdata_out[31:16] == 16'h0000)
    else $error("upper read half not zero");

  // A port 0 edge always lands in the flag register
  a_flag_set_wins: assert property (
    (|port0_rise) |=> ((pm[dcrm_pkg::PM_PORT0_IRQ_FLAGS] & $past(port0_rise)) == $past(port0_rise)))
    else $error("port flag edge lost");

  // Processing writes to a refused module leave supervisory ports alone
  a_dsp_per_keep: assert property (
    (psel_in && penable_in && pwrite_in && core && mod == 4'h1) |=> $stable(port0_out))
    else $error("processing write reached supervisory port");

  // Supervisory ident reads show no module five bit or above
  a_usr_ident: assert property (
    (s_setup ##0 (!core && mod == dcrm_pkg::MOD_SYS && rno == dcrm_pkg::R_IIR))
    |=> prdata_out[15:5] == 11'h000)
    else $error("supervisory ident shows absent bits");

  // Processing ident reads show module zero only
  a_dsp_ident: assert property (
    (s_setup ##0 (core && mod == dcrm_pkg::MOD_SYS && rno == dcrm_pkg::R_IIR))
    |=> prdata_out[15:1] == 15'h0000)
    else $error("processing ident shows absent bits");

  // Supervisory clock control keeps no stop bit and nothing above bit 6
  a_usr_clock_control_register: assert property (
    sysr[0][dcrm_pkg::S_CLOCK_CONTROL_REGISTER][15:7] == 9'h000 && !sysr[0][dcrm_pkg::S_CLOCK_CONTROL_REGISTER][4])
    else $error("supervisory clock control holds absent bits");

  // Supervisory system control keeps nothing above bit 7
  a_usr_sc_high: assert property (
    sysr[0][dcrm_pkg::S_SC][15:8] == 8'h00)
    else $error("supervisory control holds absent high bits");

endmodule : dcrm_top

`default_nettype wire

// ---- tb.sv ----
// Self-checking bench for the dual-core register map.
// Assumes dcrm_pkg and dcrm_top are compiled first; the bench is the APB master.
`timescale 1ns/1ps
`default_nettype none

module tb;
  // ==========================================================
  // Row of the table: address, write value, expected read and error
  typedef struct packed {
    logic        core;
    logic [3:0]  md;
    logic [4:0]  rg;
    logic [15:0] wd;
    logic [15:0] ex;
    logic        er;
  } dcrm_row_t;

  logic        clk_in = 1'b0;              // 20 MHz clock
  logic        srst_in = 1'b1;             // Synchronous reset
  logic        psel_in = 1'b0;             // APB request lines
  logic        penable_in = 1'b0;
  logic        pwrite_in = 1'b0;
  logic [11:0] paddr_in = 12'h000;
  logic [31:0] pwdata_in = 32'h00000000;
  logic        pready_out;                 // APB answer lines
  logic [31:0] prdata_out;
  logic        pslverr_out;
  logic [15:0] adc_high_in [6];            // Converter sources
  logic [15:0] adc_low_in  [6];
  logic [15:0] port0_pins_in = 16'h0000;   // Port pins
  logic [15:0] port1_pins_in = 16'h0000;
  logic [4:0]  usr_pending_in = 5'h00;     // Ident sources
  logic        dsp_pending_in = 1'b0;
  logic [15:0] port0_out;                  // Register-driven controls
  logic [15:0] port1_out;
  logic [4:0]  usr_irq_mask_out;
  logic        dsp_irq_mask_out;
  logic        fll_mode_out;
  logic        fll_select_out;
  int          fail_count = 0;             // Mismatches seen
  int          total_checks = 0;           // Comparisons made
  logic [31:0] rd;                         // Last read data
  logic        er;                         // Last error flag

  // Ordinary cases: write all ones, read back the implemented bits
  dcrm_row_t rows [14] = '{
    '{1'b0, 4'h8, 5'h00, 16'hFFFF, 16'h001F, 1'b0},
    '{1'b0, 4'h8, 5'h01, 16'hFFFF, 16'h00D7, 1'b0},
    '{1'b0, 4'h8, 5'h0E, 16'hFFFF, 16'h006F, 1'b0},
    '{1'b0, 4'h8, 5'h0F, 16'hFFFF, 16'h00FF, 1'b0},
    '{1'b1, 4'h8, 5'h00, 16'hFFFF, 16'h0001, 1'b0},
    '{1'b1, 4'h8, 5'h01, 16'hFFFF, 16'h0000, 1'b0},
    '{1'b1, 4'h8, 5'h0E, 16'hFFFF, 16'h0007, 1'b0},
    '{1'b1, 4'h8, 5'h0F, 16'hFFFF, 16'h0000, 1'b0},
    '{1'b0, 4'h0, 5'h11, 16'hFFFF, 16'hFF7F, 1'b0},
    '{1'b0, 4'h1, 5'h00, 16'hFFFF, 16'hFFFF, 1'b0},
    '{1'b0, 4'h1, 5'h01, 16'hFFFF, 16'hFFFF, 1'b0},
    '{1'b0, 4'h4, 5'h1F, 16'hFFFF, 16'h0000, 1'b0},
    '{1'b0, 4'h5, 5'h00, 16'hFFFF, 16'h0000, 1'b1},
    '{1'b1, 4'h1, 5'h00, 16'hFFFF, 16'h0000, 1'b1}
  };

  dcrm_top dut_u (
    .clk_in(clk_in), .srst_in(srst_in), .psel_in(psel_in), .penable_in(penable_in),
    .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
    .pready_out(pready_out), .prdata_out(prdata_out), .pslverr_out(pslverr_out),
    .adc_high_in(adc_high_in), .adc_low_in(adc_low_in), .port0_pins_in(port0_pins_in),
    .port1_pins_in(port1_pins_in), .usr_pending_in(usr_pending_in),
    .dsp_pending_in(dsp_pending_in), .port0_out(port0_out), .port1_out(port1_out),
    .usr_irq_mask_out(usr_irq_mask_out), .dsp_irq_mask_out(dsp_irq_mask_out),
    .fll_mode_out(fll_mode_out), .fll_select_out(fll_select_out)
  );

  // Clock generator
  always #25 clk_in = ~clk_in;

  // ==========================================================
  // Verdict and end of run
  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : summarize

  // One comparison
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // One APB transfer: setup, access until pready, release, one idle edge
  task automatic apb(input logic wr, input logic c, input logic [3:0] m,
                     input logic [4:0] r, input logic [15:0] wd);
    int n;
    psel_in    <= 1'b1;
    penable_in <= 1'b0;
    pwrite_in  <= wr;
    paddr_in   <= {c, m, r, 2'b00};
    pwdata_in  <= {16'hA5A5, wd};
    @(posedge clk_in);
    penable_in <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (pready_out !== 1'b1 && n < 20);
    if (pready_out !== 1'b1) begin
      fail_count++;
      $display("mismatch pready expected 1 seen %b", pready_out);
      summarize();
    end
    rd = prdata_out;
    er = pslverr_out;
    psel_in    <= 1'b0;
    penable_in <= 1'b0;
    @(posedge clk_in);
  endtask : apb

  // ==========================================================
  // Main sequence
  initial begin
    for (int i = 0; i < 6; i++) begin
      adc_high_in[i] = 16'h1000 + 16'(i);
      adc_low_in[i]  = 16'h2000 + 16'(i);
    end
    repeat (5) @(posedge clk_in);
    srst_in <= 1'b0;
    @(posedge clk_in);
    // Table rows
    foreach (rows[i]) begin
      apb(1'b1, rows[i].core, rows[i].md, rows[i].rg, rows[i].wd);
      apb(1'b0, rows[i].core, rows[i].md, rows[i].rg, 16'h0000);
      chk("row data", {16'h0000, rows[i].ex}, rd);
      chk("row error", {31'h0, rows[i].er}, {31'h0, er});
    end
    chk("port0 out", 32'h0000FFFF, {16'h0, port0_out});
    chk("port1 out", 32'h0000FFFF, {16'h0, port1_out});
    chk("usr mask", 32'h0000001F, {27'h0, usr_irq_mask_out});
    chk("dsp mask", 32'h00000001, {31'h0, dsp_irq_mask_out});
    chk("fll mode", 32'h00000001, {31'h0, fll_mode_out});
    chk("fll select", 32'h00000001, {31'h0, fll_select_out});
    // Cores keep separate sets; clock control write sets loop mode, clears select
    apb(1'b1, 1'b1, 4'h8, 5'h00, 16'h0000);
    chk("dsp mask clr", 32'h00000000, {31'h0, dsp_irq_mask_out});
    chk("usr mask kept", 32'h0000001F, {27'h0, usr_irq_mask_out});
    apb(1'b1, 1'b0, 4'h8, 5'h0E, 16'h0020);
    chk("fll mode only", 32'h00000001, {31'h0, fll_mode_out});
    chk("fll sel clr", 32'h00000000, {31'h0, fll_select_out});
    // Ident registers
    usr_pending_in <= 5'h1F;
    dsp_pending_in <= 1'b1;
    @(posedge clk_in);
    apb(1'b0, 1'b0, 4'h8, 5'h0B, 16'h0000);
    chk("usr ident", 32'h0000001F, rd);
    apb(1'b0, 1'b1, 4'h8, 5'h0B, 16'h0000);
    chk("dsp ident", 32'h00000001, rd);
    // Converter outputs are read only
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, 1'b0, 4'h0, 5'(i), 16'hFFFF);
      apb(1'b0, 1'b0, 4'h0, 5'(i), 16'h0000);
      chk("adc high", {16'h0, 16'h1000 + 16'(i)}, rd);
      apb(1'b0, 1'b0, 4'h0, 5'(8 + i), 16'h0000);
      chk("adc low", {16'h0, 16'h2000 + 16'(i)}, rd);
    end
    // Port input and edge flags
    port0_pins_in <= 16'hA5A5;
    repeat (4) @(posedge clk_in);
    apb(1'b0, 1'b0, 4'h1, 5'h02, 16'h0000);
    chk("port0 in", 32'h0000A5A5, rd);
    apb(1'b0, 1'b0, 4'h1, 5'h04, 16'h0000);
    chk("port0 flags", 32'h0000A5A5, rd);
    apb(1'b1, 1'b0, 4'h1, 5'h04, 16'h0000);
    apb(1'b0, 1'b0, 4'h1, 5'h04, 16'h0000);
    chk("flags clear", 32'h00000000, rd);
    // Reset in mid-run
    srst_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    srst_in <= 1'b0;
    @(posedge clk_in);
    chk("port0 reset", 32'h00000000, {16'h0, port0_out});
    chk("fll reset", 32'h00000000, {31'h0, fll_mode_out});
    apb(1'b0, 1'b0, 4'h8, 5'h00, 16'h0000);
    chk("mask reset", 32'h00000000, rd);
    summarize();
  end
endmodule : tb

`default_nettype wire
